// ---- logic/can_timing_objects.sv ----
/*
 * Bit timing engine and message object register page of the CAN controller.
 * Assumes a single 8-bit register port on sys_clk and frame logic that
 * reports received, transmitted and errored frames as one-cycle events.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Time quantum is clock divided by prescaler plus one.
// - Jump width field bits 6-5 gives quantum times value plus one.
// - Resynchronise on falling bus edges, lengthening or shortening bits within jump width.
// - Propagation field bits 3-1 gives quantum times value plus one.
// - Phase two field bits 6-4; may shrink by at most jump width.
// - Phase one field bits 3-1; may grow by at most jump width.
// - Sample type 0 samples once; 1 takes majority of three half-quantum samples.
// - Reserved timing bits are dropped on write and read zero; software writes them as zero.
// - Page bits 7-4 select object 0 to 14.
// - Page bit 3 low auto-increments the byte index after data access.
// - Page bits 2-0 select the data byte of the object.
// - Mode bits 7-6: disabled, transmit, receive, receive buffer.
// - Reply-valid bit 5 marks an automatic reply as ready.
// - Extension bit picks 11-bit or 29-bit identifier frames.
// - Received frames overwrite the four-bit data length field.
// - Received length differing from expected sets the length warning bit 7.
module can_timing_objects (
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire can_pkg::sfr_req_t    sfr_req,
    output logic [7:0]                sfr_rdata,
    input  wire logic                 controller_global_enable,
    input  wire logic                 can_rx_pin,
    input  wire can_pkg::rx_event_t   rx_event,
    input  wire can_pkg::tx_event_t   tx_event,
    input  wire can_pkg::err_event_t  err_event,
    output logic [14:0]               object_enable_status,
    output logic                      bit_start,
    output logic                      sample_point,
    output logic                      rx_bit
);
    typedef struct packed {
        logic [7:0]             page;
        logic [7:0]             prescale;
        logic [7:0]             bt2;
        logic [7:0]             bt3;
        logic [14:0][7:0]       ctrl;
        logic [14:0][7:0]       status;
        logic [14:0][7:0][7:0]  data;
        logic [14:0]            obj_en;
        logic [7:0]             rdata;
        logic [2:0]             rx_sync;
        logic                   rx_level;
        can_pkg::seg_state_t    seg;
        logic [3:0]             qcnt;
        logic [4:0]             pos;
        logic [3:0]             ph1_ext;
        logic [3:0]             ph2_len;
        logic                   resynced;
        logic                   bit_start;
        logic                   sample_pt;
    } ctl_t;

    ctl_t st_r;
    ctl_t st_nxt;

    logic tq_tick;
    logic half_tick;
    logic sample_now;
    logic rx_edge;

    function automatic logic obj_ok(input logic [3:0] obj);
        obj_ok = obj <= can_pkg::LAST_OBJECT;
    endfunction

    function automatic logic [3:0] plus_one3(input logic [2:0] v);
        plus_one3 = {1'b0, v} + 4'h1;
    endfunction

    logic [3:0] sel_obj;
    logic [2:0] sel_idx;
    logic [3:0] sjw_q;
    logic [3:0] prop_q;
    logic [3:0] ph1_q;
    logic [3:0] ph2_q;

    assign sel_obj = st_r.page[7:can_pkg::PAGE_OBJ_LSB];
    assign sel_idx = st_r.page[2:0];
    assign sjw_q = {2'b00, st_r.bt2[can_pkg::BT2_SJW_LSB +: 2]} + 4'h1;
    assign prop_q = plus_one3(st_r.bt2[can_pkg::BT2_PRS_LSB +: 3]);
    assign ph1_q = plus_one3(st_r.bt3[can_pkg::BT3_PH1_LSB +: 3]) + st_r.ph1_ext;
    assign ph2_q = plus_one3(st_r.bt3[can_pkg::BT3_PH2_LSB +: 3]);
    assign rx_edge = st_r.rx_level && (st_r.rx_sync[2] == st_r.rx_sync[1]) && !st_r.rx_sync[2];

    tq_divider u_div (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .run            (controller_global_enable),
        .baud_prescaler (st_r.prescale[can_pkg::BRP_LSB +: 6]),
        .tq_tick        (tq_tick),
        .half_tick      (half_tick)
    );

    triple_sampler u_smp (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .rx_level  (st_r.rx_level),
        .shift     (tq_tick | half_tick),
        .sample    (sample_now),
        .triple    (st_r.bt3[can_pkg::BT3_SMP_BIT]),
        .bit_value (rx_bit)
    );

    always_comb begin
        logic       resync;
        logic [3:0] rem;
        logic       data_acc;
        st_nxt = st_r;
        resync = 1'b0;
        rem = 4'h0;
        data_acc = 1'b0;
        sample_now = 1'b0;
        st_nxt.bit_start = 1'b0;
        st_nxt.sample_pt = 1'b0;

        // Bus input: three stages, a change counts once the last two agree.
        st_nxt.rx_sync = {st_r.rx_sync[1:0], can_rx_pin};
        if (st_r.rx_sync[2] == st_r.rx_sync[1]) begin
            st_nxt.rx_level = st_r.rx_sync[2];
        end

        // A resync is applied on top of a quantum tick in the same cycle. Deferring it
        // would stall the bit engine outright when every cycle is a tick.
        resync = rx_edge && !st_r.resynced;
        if (!controller_global_enable) begin
            st_nxt.seg = can_pkg::SEG_SYNC;
            st_nxt.qcnt = 4'h0;
            st_nxt.pos = 5'h00;
            st_nxt.ph1_ext = 4'h0;
            st_nxt.ph2_len = ph2_q;
            st_nxt.resynced = 1'b0;
        end else if (tq_tick) begin
            st_nxt.qcnt = st_r.qcnt + 4'h1;
            case (st_r.seg)
                can_pkg::SEG_SYNC: begin
                    st_nxt.seg = can_pkg::SEG_PROP;
                    st_nxt.qcnt = 4'h0;
                    st_nxt.pos = 5'h01;
                    st_nxt.ph1_ext = 4'h0;
                    st_nxt.ph2_len = ph2_q;
                    st_nxt.resynced = 1'b0;
                    st_nxt.bit_start = 1'b1;
                end
                can_pkg::SEG_PROP: begin
                    st_nxt.pos = st_r.pos + 5'h01;
                    if (st_r.qcnt == prop_q - 4'h1) begin
                        st_nxt.seg = can_pkg::SEG_PH1;
                        st_nxt.qcnt = 4'h0;
                    end
                end
                can_pkg::SEG_PH1: begin
                    st_nxt.pos = st_r.pos + 5'h01;
                    if (st_r.qcnt == ph1_q - 4'h1) begin
                        sample_now = 1'b1;
                        st_nxt.sample_pt = 1'b1;
                        st_nxt.seg = can_pkg::SEG_PH2;
                        st_nxt.qcnt = 4'h0;
                    end
                end
                can_pkg::SEG_PH2: begin
                    if (st_r.qcnt == st_r.ph2_len - 4'h1) begin
                        st_nxt.seg = can_pkg::SEG_SYNC;
                        st_nxt.qcnt = 4'h0;
                    end
                end
                default: begin
                    st_nxt.seg = can_pkg::SEG_SYNC;
                end
            endcase
        end

        // The remaining count is taken after this cycle's tick, so a shortened phase two
        // always stays at least one quantum ahead of the counter.
        if (controller_global_enable && resync) begin
            st_nxt.resynced = 1'b1;
            case (st_r.seg)
                can_pkg::SEG_PROP, can_pkg::SEG_PH1: begin
                    st_nxt.ph1_ext = ({1'b0, sjw_q} < st_r.pos) ? sjw_q : st_r.pos[3:0];
                end
                can_pkg::SEG_PH2: begin
                    rem = st_r.ph2_len - st_nxt.qcnt;
                    if (rem <= sjw_q) begin
                        st_nxt.seg = can_pkg::SEG_SYNC;
                        st_nxt.qcnt = 4'h0;
                    end else begin
                        st_nxt.ph2_len = st_r.ph2_len - sjw_q;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register writes. Reserved timing bits are dropped, so they read zero.
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                can_pkg::ADDR_PAGE: st_nxt.page = sfr_req.wdata;
                can_pkg::ADDR_PRESCALE: st_nxt.prescale = sfr_req.wdata & can_pkg::BRP_MASK;
                can_pkg::ADDR_BT2: st_nxt.bt2 = sfr_req.wdata & can_pkg::BT2_MASK;
                can_pkg::ADDR_BT3: st_nxt.bt3 = sfr_req.wdata & can_pkg::BT3_MASK;
                can_pkg::ADDR_STATUS: begin
                    if (obj_ok(sel_obj)) begin
                        st_nxt.status[sel_obj] = sfr_req.wdata;
                    end
                end
                can_pkg::ADDR_CTRL: begin
                    if (obj_ok(sel_obj)) begin
                        // Mode, reply-valid and extension bits are stored for frame logic.
                        st_nxt.ctrl[sel_obj] = sfr_req.wdata;
                        st_nxt.obj_en[sel_obj] =
                            sfr_req.wdata[can_pkg::CTRL_MODE_LSB +: 2] != can_pkg::MODE_DISABLED;
                    end
                end
                can_pkg::ADDR_DATA: begin
                    data_acc = 1'b1;
                    if (obj_ok(sel_obj)) begin
                        st_nxt.data[sel_obj][sel_idx] = sfr_req.wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        if (sfr_req.rd) begin
            st_nxt.rdata = 8'h00;
            case (sfr_req.addr)
                can_pkg::ADDR_PAGE: st_nxt.rdata = st_r.page;
                can_pkg::ADDR_PRESCALE: st_nxt.rdata = st_r.prescale;
                can_pkg::ADDR_BT2: st_nxt.rdata = st_r.bt2;
                can_pkg::ADDR_BT3: st_nxt.rdata = st_r.bt3;
                can_pkg::ADDR_STATUS: begin
                    if (obj_ok(sel_obj)) begin
                        st_nxt.rdata = st_r.status[sel_obj];
                    end
                end
                can_pkg::ADDR_CTRL: begin
                    if (obj_ok(sel_obj)) begin
                        st_nxt.rdata = st_r.ctrl[sel_obj];
                    end
                end
                can_pkg::ADDR_DATA: begin
                    data_acc = 1'b1;
                    if (obj_ok(sel_obj)) begin
                        st_nxt.rdata = st_r.data[sel_obj][sel_idx];
                    end
                end
                default: begin
                end
            endcase
        end

        if (data_acc && !st_r.page[can_pkg::PAGE_INDEX_AUTOINC_N_BIT]) begin
            st_nxt.page[2:0] = sel_idx + 3'h1;
        end

        // Frame events come after software so hardware sets win over clears.
        if (rx_event.valid && obj_ok(rx_event.obj)) begin
            st_nxt.ctrl[rx_event.obj][can_pkg::CTRL_DLC_LSB +: 4] = rx_event.dlc;
            st_nxt.status[rx_event.obj][can_pkg::ST_RX_DONE] = 1'b1;
            st_nxt.obj_en[rx_event.obj] = 1'b0;
            if (rx_event.dlc != st_r.ctrl[rx_event.obj][can_pkg::CTRL_DLC_LSB +: 4]) begin
                st_nxt.status[rx_event.obj][can_pkg::ST_LEN_WARN] = 1'b1;
            end
        end
        if (tx_event.valid && obj_ok(tx_event.obj)) begin
            st_nxt.status[tx_event.obj][can_pkg::ST_TX_DONE] = 1'b1;
            st_nxt.obj_en[tx_event.obj] = 1'b0;
        end
        if (err_event.valid && obj_ok(err_event.obj)) begin
            st_nxt.status[err_event.obj][4:0] =
                st_nxt.status[err_event.obj][4:0] | err_event.flags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.page <= can_pkg::PAGE_RESET;
            st_r.prescale <= can_pkg::TIMING_RESET;
            st_r.bt2 <= can_pkg::TIMING_RESET;
            st_r.bt3 <= can_pkg::TIMING_RESET;
            st_r.ctrl <= {15{can_pkg::CTRL_RESET}};
            st_r.status <= {15{can_pkg::STATUS_RESET}};
            st_r.rx_sync <= 3'b111;
            st_r.rx_level <= 1'b1;
            st_r.ph2_len <= 4'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign object_enable_status = st_r.obj_en;
    assign bit_start = st_r.bit_start;
    assign sample_point = st_r.sample_pt;

    a_idx_autoinc: assert property (@(posedge sys_clk) disable iff (srst)
        sfr_req.wr && sfr_req.addr == can_pkg::ADDR_DATA && !st_r.page[3]
        |=> st_r.page[2:0] == $past(st_r.page[2:0]) + 3'h1)
        else $error("Byte index did not advance after data access.");
    a_idx_hold: assert property (@(posedge sys_clk) disable iff (srst)
        sfr_req.rd && !sfr_req.wr && sfr_req.addr == can_pkg::ADDR_DATA && st_r.page[3]
        |=> st_r.page == $past(st_r.page))
        else $error("Byte index moved with auto-increment off.");
    a_rx_dlc_load: assert property (@(posedge sys_clk) disable iff (srst)
        rx_event.valid && rx_event.obj <= 4'hE
        |=> st_r.ctrl[$past(rx_event.obj)][3:0] == $past(rx_event.dlc))
        else $error("Received length not stored.");
    a_len_warn: assert property (@(posedge sys_clk) disable iff (srst)
        rx_event.valid && rx_event.obj <= 4'hE
        && rx_event.dlc != st_r.ctrl[rx_event.obj][3:0]
        |=> st_r.status[$past(rx_event.obj)][7])
        else $error("Length warning not raised.");
    a_mode_enable: assert property (@(posedge sys_clk) disable iff (srst)
        sfr_req.wr && sfr_req.addr == can_pkg::ADDR_CTRL && sel_obj <= 4'hE
        && sfr_req.wdata[7:6] != 2'b00 && !rx_event.valid && !tx_event.valid
        |=> st_r.obj_en[$past(sel_obj)])
        else $error("Object enable not set by mode write.");
    a_ext_bound: assert property (@(posedge sys_clk) disable iff (srst)
        st_r.ph1_ext <= sjw_q)
        else $error("Phase one lengthened beyond jump width.");
    a_sample_end_ph1: assert property (@(posedge sys_clk) disable iff (srst)
        sample_point |-> $past(st_r.seg) == can_pkg::SEG_PH1 && st_r.seg == can_pkg::SEG_PH2)
        else $error("Sample point outside the end of phase one.");
    a_prop_length: assert property (@(posedge sys_clk) disable iff (srst)
        st_r.seg == can_pkg::SEG_PROP |-> st_r.qcnt < prop_q)
        else $error("Propagation segment overran its length.");
endmodule
`default_nettype wire

// ---- logic/can_pkg.sv ----
/*
 * Shared constants and carrier types for the CAN bit timing and message
 * object control block. Assumes an 8-bit special function register port.
 */
package can_pkg;

    localparam logic [7:0] ADDR_PAGE     = 8'hB1;
    localparam logic [7:0] ADDR_STATUS   = 8'hB2;
    localparam logic [7:0] ADDR_CTRL     = 8'hB3;
    localparam logic [7:0] ADDR_PRESCALE = 8'hB4;
    localparam logic [7:0] ADDR_BT2      = 8'hB5;
    localparam logic [7:0] ADDR_BT3      = 8'hB6;
    localparam logic [7:0] ADDR_DATA     = 8'hFA;

    localparam logic [3:0] LAST_OBJECT = 4'hE;

    localparam int PAGE_OBJ_LSB  = 4;
    localparam int PAGE_INDEX_AUTOINC_N_BIT = 3;
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_DLC_LSB  = 0;
    localparam int BT2_SJW_LSB   = 5;
    localparam int BT2_PRS_LSB   = 1;
    localparam int BT3_PH2_LSB   = 4;
    localparam int BT3_PH1_LSB   = 1;
    localparam int BT3_SMP_BIT   = 0;
    localparam int BRP_LSB       = 1;
    localparam int ST_LEN_WARN   = 7;
    localparam int ST_TX_DONE    = 6;
    localparam int ST_RX_DONE    = 5;

    localparam logic [7:0] BRP_MASK = 8'h7E;
    localparam logic [7:0] BT2_MASK = 8'h6E;
    localparam logic [7:0] BT3_MASK = 8'h7F;

    localparam logic [7:0] PAGE_RESET   = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        MODE_DISABLED  = 2'b00,
        MODE_TX        = 2'b01,
        MODE_RX        = 2'b10,
        MODE_RX_BUFFER = 2'b11
    } object_mode_t;

    typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] obj;
        logic [3:0] dlc;
    } rx_event_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] obj;
    } tx_event_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] obj;
        logic [4:0] flags;
    } err_event_t;

endpackage

// ---- logic/tq_divider.sv ----
/*
 * Time quantum divider: one-cycle tick every prescaler plus one clocks and
 * a half tick midway. Assumes the prescaler is stable while run is high.
 */
`timescale 1ns/1ps
`default_nettype none
module tq_divider (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic [5:0] baud_prescaler,
    output logic            tq_tick,
    output logic            half_tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       tq;
        logic       half;
    } div_t;

    div_t st_r;
    div_t st_nxt;
    logic [6:0] gap_r;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tq = 1'b0;
        st_nxt.half = 1'b0;
        if (!run) begin
            st_nxt.cnt = 6'h00;
        end else if (st_r.cnt == baud_prescaler) begin
            st_nxt.cnt = 6'h00;
            st_nxt.tq = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
        end
        // An even split is impossible for odd divisors; the half tick lands late, and a divisor of one gives none.
        if (run && baud_prescaler != 6'h00 && st_r.cnt == (baud_prescaler >> 1)) begin
            st_nxt.half = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '0;
            gap_r <= 7'h00;
        end else begin
            st_r <= st_nxt;
            gap_r <= (st_r.tq || !run) ? 7'h00 : gap_r + 7'h01;
        end
    end

    assign tq_tick = st_r.tq;
    assign half_tick = st_r.half;

    a_tq_period: assert property (@(posedge sys_clk) disable iff (srst)
        run && $past(run, 70) && $stable(baud_prescaler) && tq_tick && $past(tq_tick, 70)
        |-> gap_r == {1'b0, baud_prescaler})
        else $error("Quantum period differs from prescaler plus one.");
endmodule
`default_nettype wire

// ---- logic/triple_sampler.sv ----
/*
 * Bus sampler: single sample, or majority of three samples half a quantum
 * apart. Assumes rx_level is already synchronised to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module triple_sampler (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic rx_level,
    input  wire logic shift,
    input  wire logic sample,
    input  wire logic triple,
    output logic      bit_value
);
    typedef struct packed {
        logic [1:0] hist;
        logic       bit_v;
    } smp_t;

    smp_t st_r;
    smp_t st_nxt;

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    always_comb begin
        st_nxt = st_r;
        if (shift) begin
            st_nxt.hist = {st_r.hist[0], rx_level};
        end
        if (sample) begin
            st_nxt.bit_v = triple ? majority(st_r.hist[1], st_r.hist[0], rx_level)
                                  : rx_level;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= 3'b111;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bit_value = st_r.bit_v;

    a_single_sample: assert property (@(posedge sys_clk) disable iff (srst)
        sample && !triple |=> bit_value == $past(rx_level))
        else $error("Single sample does not follow the bus level.");
    a_triple_vote: assert property (@(posedge sys_clk) disable iff (srst)
        sample && triple |=> bit_value == majority($past(st_r.hist[1]),
                                                   $past(st_r.hist[0]), $past(rx_level)))
        else $error("Triple sample does not take the majority.");
endmodule
`default_nettype wire

// ---- tb/can_bus_node.sv ----
/* Far-side CAN node: sends one byte MSB first, bit_clks clocks per bit.
   Assumes the bench clock; the line idles recessive between frames. */
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
    input  wire logic       sys_clk,
    input  wire logic       send,
    input  wire logic [7:0] frame,
    input  wire logic [9:0] bit_clks,
    output logic            can_rx_pin
);
    logic [7:0] sh_r;
    logic       line_r = 1'b1;
    int         cnt_r = 0;
    int         left_r = 0;
    assign can_rx_pin = line_r;
    always @(posedge sys_clk) begin
        if (send) begin
            sh_r <= frame;
            left_r <= 8;
            cnt_r <= 0;
        end else if (left_r > 0) begin
            line_r <= sh_r[7];
            if (cnt_r == int'(bit_clks) - 1) begin
                cnt_r <= 0;
                sh_r <= sh_r << 1;
                left_r <= left_r - 1;
            end else begin
                cnt_r <= cnt_r + 1;
            end
        end else begin
            line_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench: registers, object events and bit timing.
   Assumes the register map and event contract of can_pkg. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                sys_clk = 1'b0;
    logic                srst = 1'b1;
    can_pkg::sfr_req_t   sfr_req = '0;
    can_pkg::rx_event_t  rx_event = '0;
    logic [7:0]          sfr_rdata;
    logic                ena = 1'b0;
    logic                can_rx_pin;
    logic [14:0]         en_st;
    logic                bit_start;
    logic                sample_point;
    logic                rx_bit;
    logic                send = 1'b0;
    logic [9:0]          bit_clks = 10'h001;
    logic [31:0]         seed = 32'h000001A2;
    logic [7:0]          v;
    logic [7:0]          dat [8];
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  cyc = 0;
    int                  q, prs, ph1, ph2, a, b, c;
    always #50 sys_clk = ~sys_clk;
    can_timing_objects i_dut (.sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .controller_global_enable(ena), .can_rx_pin(can_rx_pin),
        .rx_event(rx_event), .tx_event('0), .err_event('0), .object_enable_status(en_st),
        .bit_start(bit_start), .sample_point(sample_point), .rx_bit(rx_bit));
    can_bus_node i_node (.sys_clk(sys_clk), .send(send), .frame(8'h00),
        .bit_clks(bit_clks), .can_rx_pin(can_rx_pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Each access takes two cycles so a strobe is never set and cleared in one step.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge sys_clk) sfr_req = {1'b1, 1'b0, ad, d};
        @(negedge sys_clk) sfr_req.wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge sys_clk) sfr_req = {1'b0, 1'b1, ad, 8'h00};
        @(negedge sys_clk) sfr_req.rd = 1'b0;
        chk(32'(sfr_rdata), 32'(exp));
    endtask
    task automatic rx_ev(input logic [3:0] o, input logic [3:0] l);
        @(negedge sys_clk) rx_event = {1'b1, o, l};
        @(negedge sys_clk) rx_event = '0;
    endtask
    task automatic wp(input logic sel, output int t);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(negedge sys_clk);
            if ((sel ? sample_point : bit_start) === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
        // A pulse that never comes is a failure, not a silent zero interval.
        if (!hit) begin
            num_errors++;
        end
        t = cyc;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) srst = 1'b0;
        foreach (dat[i]) rchk(8'hB1 + 8'(i % 6), 8'h00);
        rchk(8'h90, 8'h00);
        // Timing fields only written with the controller off, reserved bits kept zero.
        repeat (4) begin
            seed = xs(seed);
            wr(can_pkg::ADDR_BT2, seed[7:0] & can_pkg::BT2_MASK);
            rchk(can_pkg::ADDR_BT2, seed[7:0] & can_pkg::BT2_MASK);
            wr(can_pkg::ADDR_BT3, seed[15:8] & can_pkg::BT3_MASK);
            rchk(can_pkg::ADDR_BT3, seed[15:8] & can_pkg::BT3_MASK);
        end
        wr(can_pkg::ADDR_PAGE, 8'h30);
        for (int m = 0; m < 4; m++) begin
            seed = xs(seed);
            v = {2'(m), seed[1:0], 4'h5};
            wr(can_pkg::ADDR_CTRL, v);
            rchk(can_pkg::ADDR_CTRL, v);
            chk(32'(en_st[3]), 32'(m != 0));
        end
        wr(can_pkg::ADDR_PAGE, 8'hF0);
        wr(can_pkg::ADDR_CTRL, 8'h80);
        rchk(can_pkg::ADDR_CTRL, 8'h00);
        wr(can_pkg::ADDR_PAGE, 8'h20);
        foreach (dat[i]) begin
            seed = xs(seed);
            dat[i] = seed[7:0];
            wr(can_pkg::ADDR_DATA, dat[i]);
        end
        wr(can_pkg::ADDR_PAGE, 8'h20);
        foreach (dat[i]) rchk(can_pkg::ADDR_DATA, dat[i]);
        wr(can_pkg::ADDR_PAGE, 8'h2D);
        repeat (2) rchk(can_pkg::ADDR_DATA, dat[5]);
        wr(can_pkg::ADDR_CTRL, 8'h84);
        rx_ev(4'h2, 4'h8);
        rchk(can_pkg::ADDR_CTRL, 8'h88);
        rchk(can_pkg::ADDR_STATUS, 8'hA0);
        wr(can_pkg::ADDR_STATUS, 8'h00);
        rx_ev(4'h2, 4'h8);
        rchk(can_pkg::ADDR_STATUS, 8'h20);
        chk(32'(en_st[2]), 32'h0);
        wr(can_pkg::ADDR_CTRL, 8'h88);
        chk(32'(en_st[2]), 32'h1);
        for (int sample_type = 0; sample_type < 2; sample_type++) begin
            seed = xs(seed);
            q = int'(seed[1:0]) + 1;
            prs = int'(seed[4:2]);
            ph1 = int'(seed[6:5]);
            ph2 = ph1 + 1;
            @(negedge sys_clk) ena = 1'b0;
            wr(can_pkg::ADDR_PRESCALE, 8'((q - 1) << 1));
            wr(can_pkg::ADDR_BT2, 8'(prs << 1));
            wr(can_pkg::ADDR_BT3, 8'((ph2 << 4) | (ph1 << 1) | sample_type));
            @(negedge sys_clk) ena = 1'b1;
            wp(1'b0, a);
            wp(1'b0, a);
            wp(1'b1, b);
            wp(1'b0, c);
            chk(32'(c - a), 32'(q * (4 + prs + ph1 + ph2)));
            chk(32'(b - a), 32'(q * (prs + ph1 + 2)));
            bit_clks = 10'(q * (4 + prs + ph1 + ph2));
            @(negedge sys_clk) send = 1'b1;
            @(negedge sys_clk) send = 1'b0;
            repeat (4 * int'(bit_clks)) @(negedge sys_clk);
            chk(32'(rx_bit), 32'h0);
            repeat (6 * int'(bit_clks)) @(negedge sys_clk);
            chk(32'(rx_bit), 32'h1);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
